//--- hdl/rtmc_bitclk.v
// bit period timer producing the gaussian transmit bit clock
`timescale 1ns/1ps
`default_nettype none
module rtmc_bitclk (
  input wire clk_sys,
  input wire srst,
  input wire run,
  input wire [7:0] div_factor,
  input wire [7:0] step_count,
  output reg bit_clk,
  output reg bit_edge
);
  reg [7:0] div_q;
  reg [7:0] step_q;
  wire div_end = (div_q >= div_factor - 8'h01) || (div_factor == 8'h00);
  wire step_end = (step_q >= step_count - 8'h01) || (step_count == 8'h00);
  // period = div_factor * step_count clocks, see [RL13]
  always @(posedge clk_sys) begin
    if (srst || !run) begin
      div_q <= 8'h00;
      step_q <= 8'h00;
      bit_clk <= 1'b0;
      bit_edge <= 1'b0;
    end else begin
      bit_edge <= 1'b0;
      if (div_end) begin
        div_q <= 8'h00;
        if (step_end) begin
          step_q <= 8'h00;
          bit_edge <= 1'b1;
          bit_clk <= 1'b0;
        end else begin
          step_q <= step_q + 8'h01;
          if (step_q == {1'b0, step_count[7:1]} - 8'h01) begin
            bit_clk <= 1'b1;
          end
        end
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/rtmc_regs.vh
// register map, field positions and constants of the transmit modulation control
`ifndef RTMC_REGS_VH
`define RTMC_REGS_VH
// Overview of operation
// [RL1] fsk and gfsk drive the amplifier at power field one regardless of input
// [RL2] in ask and ook a control bit sets the transmit input polarity
// [RL3] ask loads the dac from field one when active, field two when inactive
// [RL4] ook drives power field one when active and mutes the amplifier otherwise
// [RL5] a two bit field sets amplifier bias current; seven microamp recommended
// [RL6] amplifier output stage is powered down while its enable bit is clear
// [RL7] host should clear amplifier enable while the synthesizer acquires lock
// [RL8] fsk shifts the divide value above or below center per transmit bit
// [RL9] nine bit deviation field, one to 511, sets fsk deviation over 2^14
// [RL10] three bit select chooses fsk, gfsk, ask, ook or gook
// [RL11] gaussian modes output a bit clock; host shifts bits in step with it
// [RL12] gfsk deviation equals comparison frequency times 2^m over 2^12
// [RL13] gfsk rate is comparison frequency over divider factor times step count
// [RL14] gook shapes on-off edges and samples bits once per bit period
// [RL15] transmit select zero closes the switch shorting the receive input
// [RL16] host programs the synthesizer 200 kHz below channel center when receiving
// [RL17] one bit selects high gain low noise or low gain low power receive amp
// [RL18] one bit selects low current or enhanced linearity mixer
// [RL19] two bit receive gain field is user writable and agc updatable
// [RL20] fields hold until rewritten or reset; modulation changes apply at bit edge; the code applies a switch into gfsk or gook from a plain mode at once

// ************************************
// register offsets (byte addresses)
// ************************************
`define RTMC_ADR_W 4
`define RTMC_OFF_TXCFG 4'h0
`define RTMC_OFF_RXCFG 4'h4
`define RTMC_OFF_RATE 4'h8
`define RTMC_OFF_STAT 4'hC

// ************************************
// transmit config fields
// ************************************
`define RTMC_PAEN_BIT 4
`define RTMC_MOD_HI 8
`define RTMC_MOD_LO 6
`define RTMC_PW1_HI 14
`define RTMC_PW1_LO 9
`define RTMC_PW2_HI 20
`define RTMC_PW2_LO 15
`define RTMC_DEV_HI 23
`define RTMC_DEV_LO 15
`define RTMC_GEXP_HI 26
`define RTMC_GEXP_LO 24
`define RTMC_POL_BIT 29
`define RTMC_BIAS_HI 31
`define RTMC_BIAS_LO 30
`define RTMC_TXCFG_RST 32'h4000_0000

// ************************************
// receive config fields
// ************************************
`define RTMC_TRX_BIT 27
`define RTMC_AMPM_BIT 15
`define RTMC_MIXL_BIT 18
`define RTMC_GAIN_HI 21
`define RTMC_GAIN_LO 20
`define RTMC_RXCFG_RST 32'h0030_0000

// ************************************
// rate fields: divider factor and step count
// ************************************
`define RTMC_DIVF_HI 7
`define RTMC_DIVF_LO 0
`define RTMC_STEP_HI 15
`define RTMC_STEP_LO 8
`define RTMC_RATE_RST 32'h0000_0101

// ************************************
// modulation codes, power off level and minimum deviation
// ************************************
`define RTMC_MOD_FSK 3'h0
`define RTMC_MOD_GFSK 3'h1
`define RTMC_MOD_ASK 3'h2
`define RTMC_MOD_OOK 3'h3
`define RTMC_MOD_GOOK 3'h4
`define RTMC_PWR_OFF 6'h00
`define RTMC_DEV_MIN 9'h001
`endif

//--- hdl/rtmc_sync.v
// two flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module rtmc_sync (
  input wire clk_sys,
  input wire srst,
  input wire din,
  output reg dout
);
  reg meta_q;
  always @(posedge clk_sys) begin
    if (srst) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- hdl/rtmc_top.v
// transmit modulation and receive front end control with wishbone slave
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_regs.vh"
module rtmc_top (
  input wire clk_sys,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire transmit_bit_input,
  input wire [1:0] agc_gain_in,
  input wire agc_gain_load,
  output reg transmit_bit_clock_out,
  output reg [5:0] power_dac_q,
  output reg power_amplifier_en_q,
  output reg [1:0] pa_bias_q,
  output reg fsk_shift_up_q,
  output reg fsk_shift_dn_q,
  output reg [8:0] fsk_dev_q,
  output reg [2:0] gauss_dev_exp_q,
  output reg gook_shape_q,
  output reg rx_input_short_switch,
  output reg rx_amp_mode_bit,
  output reg mixer_linear_q,
  output reg [1:0] rx_amp_gain_field
);
  // ************************************
  // registers
  // ************************************
  reg [31:0] txcfg_q;
  reg [31:0] rxcfg_q;
  reg [31:0] rate_q;
  wire [31:0] wmask;
  reg [2:0] mod_act_q;
  reg [8:0] dev_act_q;
  reg [2:0] gexp_act_q;
  reg pol_act_q;
  reg [5:0] pw1_act_q;
  reg [5:0] pw2_act_q;
  reg txbit_q;
  reg txbit_prev_q;
  reg [1:0] gook_ramp_q;
  wire txbit_s;
  wire bclk;
  wire bedge;
  wire gauss_mode;
  wire active_bit;
  wire wr_stb;
  wire [2:0] mod_sel;
  genvar g;

  // transmit pin is asynchronous to clk_sys
  rtmc_sync u_sync_tx (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(transmit_bit_input),
    .dout(txbit_s)
  );

  assign mod_sel = txcfg_q[`RTMC_MOD_HI:`RTMC_MOD_LO];
  assign gauss_mode = (mod_act_q == `RTMC_MOD_GFSK) || (mod_act_q == `RTMC_MOD_GOOK);

  rtmc_bitclk u_bitclk (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(gauss_mode),
    .div_factor(rate_q[`RTMC_DIVF_HI:`RTMC_DIVF_LO]),
    .step_count(rate_q[`RTMC_STEP_HI:`RTMC_STEP_LO]),
    .bit_clk(bclk),
    .bit_edge(bedge)
  );

  // ************************************
  // wishbone slave
  // ************************************
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_mask
      assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
        case (wb_adr_i)
          `RTMC_OFF_TXCFG: wb_dat_o <= txcfg_q;
          `RTMC_OFF_RXCFG: wb_dat_o <= rxcfg_q;
          `RTMC_OFF_RATE: wb_dat_o <= rate_q;
          `RTMC_OFF_STAT: wb_dat_o <= {24'h00_0000, gook_ramp_q, txbit_q, mod_act_q,
                                       power_amplifier_en_q, gauss_mode};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // fields hold until rewritten or reset, see [RL20]
  always @(posedge clk_sys) begin
    if (srst) begin
      txcfg_q <= `RTMC_TXCFG_RST;
      rxcfg_q <= `RTMC_RXCFG_RST;
      rate_q <= `RTMC_RATE_RST;
    end else begin
      if (wr_stb && wb_adr_i == `RTMC_OFF_TXCFG) begin
        txcfg_q <= (txcfg_q & ~wmask) | (wb_dat_i & wmask);
      end
      if (wr_stb && wb_adr_i == `RTMC_OFF_RATE) begin
        rate_q <= (rate_q & ~wmask) | (wb_dat_i & wmask);
      end
      if (wr_stb && wb_adr_i == `RTMC_OFF_RXCFG) begin
        rxcfg_q <= (rxcfg_q & ~wmask) | (wb_dat_i & wmask);
      end else if (agc_gain_load) begin
        // agc may overwrite the gain field, see [RL19]
        rxcfg_q[`RTMC_GAIN_HI:`RTMC_GAIN_LO] <= agc_gain_in;
      end
    end
  end

  // ************************************
  // modulation fields taken at bit boundary, or at once when a gaussian mode is selected from a plain one
  // ************************************
  wire bit_bound = gauss_mode ? bedge : (txbit_s != txbit_prev_q);
  wire idle_load = !gauss_mode && (mod_sel == `RTMC_MOD_GFSK || mod_sel == `RTMC_MOD_GOOK);
  always @(posedge clk_sys) begin
    if (srst) begin
      mod_act_q <= `RTMC_MOD_FSK;
      dev_act_q <= `RTMC_DEV_MIN;
      gexp_act_q <= 3'h0;
      pol_act_q <= 1'b0;
      pw1_act_q <= `RTMC_PWR_OFF;
      pw2_act_q <= `RTMC_PWR_OFF;
      txbit_q <= 1'b0;
      txbit_prev_q <= 1'b0;
    end else begin
      txbit_prev_q <= txbit_s;
      // gaussian modes sample once per bit, see [RL14]
      if (!gauss_mode || bedge) begin
        txbit_q <= txbit_s;
      end
      if (bit_bound || idle_load) begin
        mod_act_q <= mod_sel; // see [RL10] [RL20]
        dev_act_q <= (txcfg_q[`RTMC_DEV_HI:`RTMC_DEV_LO] == 9'h000) ? `RTMC_DEV_MIN
                     : txcfg_q[`RTMC_DEV_HI:`RTMC_DEV_LO];
        gexp_act_q <= txcfg_q[`RTMC_GEXP_HI:`RTMC_GEXP_LO];
        pol_act_q <= txcfg_q[`RTMC_POL_BIT];
        pw1_act_q <= txcfg_q[`RTMC_PW1_HI:`RTMC_PW1_LO];
        pw2_act_q <= txcfg_q[`RTMC_PW2_HI:`RTMC_PW2_LO];
      end
    end
  end

  // polarity picks active level, see [RL2]
  assign active_bit = txbit_q ^ pol_act_q;

  // ************************************
  // power amplifier and frequency outputs
  // ************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      power_dac_q <= `RTMC_PWR_OFF;
      power_amplifier_en_q <= 1'b0;
      pa_bias_q <= 2'h0;
      fsk_shift_up_q <= 1'b0;
      fsk_shift_dn_q <= 1'b0;
      fsk_dev_q <= `RTMC_DEV_MIN;
      gauss_dev_exp_q <= 3'h0;
      gook_shape_q <= 1'b0;
      gook_ramp_q <= 2'h0;
      transmit_bit_clock_out <= 1'b0;
    end else begin
      power_amplifier_en_q <= txcfg_q[`RTMC_PAEN_BIT]; // see [RL6]
      pa_bias_q <= txcfg_q[`RTMC_BIAS_HI:`RTMC_BIAS_LO]; // see [RL5]
      fsk_dev_q <= dev_act_q; // see [RL9]
      gauss_dev_exp_q <= gexp_act_q; // see [RL12]
      transmit_bit_clock_out <= gauss_mode && bclk; // see [RL11]
      fsk_shift_up_q <= 1'b0;
      fsk_shift_dn_q <= 1'b0;
      gook_shape_q <= 1'b0;
      if (!txcfg_q[`RTMC_PAEN_BIT]) begin
        power_dac_q <= `RTMC_PWR_OFF;
      end else begin
        case (mod_act_q)
          `RTMC_MOD_FSK, `RTMC_MOD_GFSK: begin
            power_dac_q <= pw1_act_q; // see [RL1]
            fsk_shift_up_q <= txbit_q; // see [RL8]
            fsk_shift_dn_q <= !txbit_q;
          end
          `RTMC_MOD_ASK: power_dac_q <= active_bit ? pw1_act_q : pw2_act_q; // see [RL3]
          `RTMC_MOD_OOK: power_dac_q <= active_bit ? pw1_act_q : `RTMC_PWR_OFF; // see [RL4]
          `RTMC_MOD_GOOK: begin
            // ramp towards the target for smooth edges, see [RL14]
            gook_shape_q <= 1'b1;
            if (active_bit && gook_ramp_q != 2'h3) begin
              gook_ramp_q <= gook_ramp_q + 2'h1;
            end else if (!active_bit && gook_ramp_q != 2'h0) begin
              gook_ramp_q <= gook_ramp_q - 2'h1;
            end
            case (gook_ramp_q)
              2'h0: power_dac_q <= `RTMC_PWR_OFF;
              2'h1: power_dac_q <= {2'h0, pw1_act_q[5:2]};
              2'h2: power_dac_q <= {1'b0, pw1_act_q[5:1]};
              default: power_dac_q <= pw1_act_q;
            endcase
          end
          default: power_dac_q <= `RTMC_PWR_OFF;
        endcase
      end
    end
  end

  // ************************************
  // receive front end
  // ************************************
  always @(posedge clk_sys) begin
    if (srst) begin
      rx_input_short_switch <= 1'b1;
      rx_amp_mode_bit <= 1'b0;
      mixer_linear_q <= 1'b0;
      rx_amp_gain_field <= 2'h0;
    end else begin
      rx_input_short_switch <= !rxcfg_q[`RTMC_TRX_BIT]; // see [RL15]
      rx_amp_mode_bit <= rxcfg_q[`RTMC_AMPM_BIT]; // see [RL17]
      mixer_linear_q <= rxcfg_q[`RTMC_MIXL_BIT]; // see [RL18]
      rx_amp_gain_field <= rxcfg_q[`RTMC_GAIN_HI:`RTMC_GAIN_LO]; // see [RL19]
    end
  end
endmodule
`default_nettype wire

//--- tb/rtmc_host_model.sv
// host model shifting transmit bits into the block
`timescale 1ns/1ps
`default_nettype none
module rtmc_host_model (
  input wire logic bit_clk,
  input wire logic gauss,
  input wire logic level,
  input wire logic [7:0] pattern,
  output logic tx_bit
);
  logic link_clk;
  logic [2:0] idx;
  initial begin
    tx_bit = 1'b0;
    idx = 3'h0;
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end
  // plain modes: level follows host timing
  always @(posedge link_clk) begin
    if (!gauss) begin
      tx_bit <= level;
    end
  end
  // next bit on each rising bit clock
  always @(posedge bit_clk) begin
    if (gauss) begin
      tx_bit <= pattern[idx];
      idx <= idx + 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/rtmc_properties.sv
// checker on the ports of the modulation control block
`timescale 1ns/1ps
`default_nettype none
module rtmc_properties (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [5:0] power_dac_q,
  input wire logic power_amplifier_en_q,
  input wire logic [1:0] pa_bias_q,
  input wire logic fsk_shift_up_q,
  input wire logic fsk_shift_dn_q,
  input wire logic [8:0] fsk_dev_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // a bus write or a reset release may move the config outputs
  sequence s_wrote;
    wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(srst) || $past(srst, 2);
  endsequence
  AST_ACK_TAKEN: assert property (s_req |=> s_ack) else $error("request not acked");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  AST_PA_MUTE: assert property (!power_amplifier_en_q [*2] |-> power_dac_q == 6'h00)
    else $error("dac live while amplifier off");
  AST_SHIFT_ONE: assert property (!(fsk_shift_up_q && fsk_shift_dn_q))
    else $error("both shift directions");
  AST_DEV_RANGE: assert property (fsk_dev_q != 9'h000) else $error("zero deviation");
  AST_BIAS_HOLD: assert property ($changed(pa_bias_q) |-> s_wrote)
    else $error("bias changed without write");
  AST_EN_HOLD: assert property ($changed(power_amplifier_en_q) |-> s_wrote)
    else $error("enable changed without write");
endmodule
bind rtmc_top rtmc_properties rtmc_properties_inst (
  .clk_sys(clk_sys),
  .srst(srst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o),
  .power_dac_q(power_dac_q),
  .power_amplifier_en_q(power_amplifier_en_q),
  .pa_bias_q(pa_bias_q),
  .fsk_shift_up_q(fsk_shift_up_q),
  .fsk_shift_dn_q(fsk_shift_dn_q),
  .fsk_dev_q(fsk_dev_q)
);
`default_nettype wire

//--- tb/rtmc_top_test.sv
// self-checking bench for the modulation control block
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_regs.vh"
module rtmc_top_test;
  logic clk_sys, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, agc_gain_load;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0] agc_gain_in, pa_bias_q, rx_amp_gain_field;
  logic transmit_bit_input, transmit_bit_clock_out, power_amplifier_en_q, gook_shape_q;
  logic fsk_shift_up_q, fsk_shift_dn_q, rx_input_short_switch, rx_amp_mode_bit, mixer_linear_q;
  logic [5:0] power_dac_q, ex;
  logic [4:0] rxf;
  logic [8:0] fsk_dev_q;
  logic [2:0] gauss_dev_exp_q, md;
  logic gauss, level, pol, b, bc_q;
  int error_cnt, n_compared, n, i, rises, up_n, dn_n;
  rtmc_top rtmc_top_inst (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .transmit_bit_input(transmit_bit_input), .agc_gain_in(agc_gain_in),
    .agc_gain_load(agc_gain_load), .transmit_bit_clock_out(transmit_bit_clock_out),
    .power_dac_q(power_dac_q), .power_amplifier_en_q(power_amplifier_en_q),
    .pa_bias_q(pa_bias_q), .fsk_shift_up_q(fsk_shift_up_q), .fsk_shift_dn_q(fsk_shift_dn_q),
    .fsk_dev_q(fsk_dev_q), .gauss_dev_exp_q(gauss_dev_exp_q), .gook_shape_q(gook_shape_q),
    .rx_input_short_switch(rx_input_short_switch), .rx_amp_mode_bit(rx_amp_mode_bit),
    .mixer_linear_q(mixer_linear_q), .rx_amp_gain_field(rx_amp_gain_field));
  assign rxf = {rx_input_short_switch, rx_amp_mode_bit, mixer_linear_q, rx_amp_gain_field};
  rtmc_host_model rtmc_host_model_inst (.bit_clk(transmit_bit_clock_out), .gauss(gauss),
    .level(level), .pattern(8'hA5), .tx_bit(transmit_bit_input));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // counts sampled mid-cycle, clear of the launching edge
  always @(negedge clk_sys) begin
    bc_q <= transmit_bit_clock_out;
    rises <= rises + int'(transmit_bit_clock_out && !bc_q);
    up_n <= up_n + int'(fsk_shift_up_q);
    dn_n <= dn_n + int'(fsk_shift_dn_q);
  end
  function automatic logic [31:0] tx(input logic [2:0] m, input logic p, input logic en);
    return {2'h1, p, 2'h0, 3'h6, 3'h5, 6'h15, 6'h2A, m, 1'b0, en, 4'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rd, e);
  endtask
  initial begin
    {srst, bc_q, rises, up_n, dn_n} = {1'b1, 1'b0, 96'h0};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 42'h0;
    {agc_gain_in, agc_gain_load, gauss, level} = 5'h0;
    {error_cnt, n_compared} = 64'h0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    rdc(4'h0, `RTMC_TXCFG_RST);
    rdc(4'h4, `RTMC_RXCFG_RST);
    rdc(4'h8, `RTMC_RATE_RST);
    rdc(4'h2, 32'h0000_0000);
    bus(1'b1, 4'h8, 32'hFFFF_FF03, 4'h1);
    rdc(4'h8, 32'h0000_0103);
    for (i = 0; i < 13; i++) begin
      md = (i < 4) ? `RTMC_MOD_FSK : (i < 8) ? `RTMC_MOD_ASK : (i < 12) ? `RTMC_MOD_OOK : 3'h5;
      {pol, b} = i[1:0];
      wr(4'h0, tx(md, pol, 1'b1));
      level <= ~b;
      repeat (30) @(posedge clk_sys);
      level <= b;
      repeat (30) @(posedge clk_sys);
      ex = (md == `RTMC_MOD_FSK || (md <= `RTMC_MOD_OOK && (b ^ pol))) ? 6'h2A :
        (md == `RTMC_MOD_ASK) ? 6'h15 : 6'h00;
      chk(power_dac_q, ex);
      if (md == `RTMC_MOD_FSK) begin
        chk({fsk_shift_up_q, fsk_shift_dn_q, fsk_dev_q}, {b, ~b, 9'h155});
      end
    end
    wr(4'h0, tx(`RTMC_MOD_FSK, 1'b0, 1'b0));
    repeat (4) @(posedge clk_sys);
    chk({power_dac_q, power_amplifier_en_q, pa_bias_q}, {6'h00, 1'b0, 2'h1});
    wr(4'h4, 32'h0024_8000);
    repeat (3) @(posedge clk_sys);
    chk(rxf, 5'h1E);
    wr(4'h4, 32'h0800_0000);
    agc_gain_in <= 2'h3;
    agc_gain_load <= 1'b1;
    @(posedge clk_sys);
    agc_gain_load <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(rxf, 5'h03);
    rdc(4'h4, 32'h0830_0000);
    wr(4'h8, 32'h0000_0503);
    gauss <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(4'h0, tx(i ? `RTMC_MOD_GOOK : `RTMC_MOD_GFSK, 1'b0, 1'b1));
      repeat (40) @(posedge clk_sys);
      {rises, up_n, dn_n} = 96'h0;
      repeat (300) @(posedge clk_sys);
      chk(rises, 20);
      chk({gook_shape_q, up_n > 0, dn_n > 0}, i ? 3'h4 : 3'h3);
      if (i == 0) begin
        chk({gauss_dev_exp_q, power_dac_q}, {3'h6, 6'h2A});
      end
    end
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rdc(4'h0, `RTMC_TXCFG_RST);
    results();
  end
endmodule
`default_nettype wire
